/* File: shared/vcarb_defines.svh */
// register offsets, field positions, reset values and timing counts for the vc0 arbitration table
// Summary of operation
// [RULE1] table write sets the coherency status bit
// [RULE2] coherency bit stays set until load completes
// [RULE3] downstream ports always read coherency as zero
// [RULE4] coherency only meaningful when scheme uses table
// [RULE5] status bit 1 shows flow control init pending
// [RULE6] sixteen 4-bit slots, ascending nibbles, two words
// [RULE7] 0 upstream, 2..5 ports, 6..f reserved
// [RULE8] invalid slot skipped with no time spent
// [RULE9] software avoids reserved or egress port codes
// [RULE10] reset slots cycle 1..7 across both words
// [RULE11] load request write-one acts, reads zero, upstream only
// [RULE12] slots stepped ascending, one per period, wrapping
`ifndef VCARB_DEFINES_SVH
`define VCARB_DEFINES_SVH
`define VCARB_OFF_STATUS     12'h218
`define VCARB_OFF_TBL0       12'h220
`define VCARB_OFF_TBL1       12'h224
`define VCARB_OFF_CTRL       12'h214
`define VCARB_BIT_COHERENCY  0
`define VCARB_BIT_FC_PEND    1
`define VCARB_BIT_LOAD_REQ   16
`define VCARB_RST_TBL0       32'h17654321
`define VCARB_RST_TBL1       32'h21765432
`define VCARB_RST_STATUS     32'h00000000
`define VCARB_LOAD_CYCLES    4'h8
`define VCARB_PERIOD_CYCLES  8'h04
`define VCARB_PORT_UP        4'h0
`define VCARB_PORT_MAX       4'h5
`define VCARB_PORT_SKIP      4'h1
`endif

/* File: shared/vcarb_pkg.sv */
// types shared by the vc0 arbitration table logic
package vcarb_pkg;
  typedef logic [3:0] vcarb_port_t;               // one phase slot
  typedef struct packed {
    logic        valid;                           // slot names a real ingress port
    vcarb_port_t port;                            // granted port id
    logic [3:0]  slot;                            // slot index that granted
  } vcarb_grant_t;
  typedef enum logic [1:0] {
    VCARB_IDLE,
    VCARB_LOAD
  } vcarb_load_state_t;
endpackage : vcarb_pkg

/* File: logic/vcarb_slot_scan.sv */
// slot stepper: walks the latched table and skips invalid slots in the same cycle
`timescale 1ns/1ns
`include "vcarb_defines.svh"
module vcarb_slot_scan
  import vcarb_pkg::*;
#(
  parameter int unsigned SLOTS = 16                 // phase slots in the table
) (
  input  wire logic                 ref_clk_in,     // core clock
  input  wire logic                 rstn_in,        // async reset, active low
  input  wire logic                 step_in,        // one-cycle arbitration period pulse
  input  wire logic [SLOTS*4-1:0]   table_in,       // latched slots, slot 0 in low nibble
  input  wire logic [3:0]           egress_in,      // own egress port id
  output vcarb_grant_t              grant_out       // registered grant
);
  logic [3:0]      ptr_q;                           // next slot to look at
  logic [SLOTS-1:0] ok;                             // per-slot validity
  logic [3:0]      pick;                            // first valid slot from ptr_q
  logic            found;                           // any valid slot at all

  // a slot is valid when it names an existing port other than ourselves
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      ok[i] = ((table_in[i*4 +: 4] == `VCARB_PORT_UP) ||
               ((table_in[i*4 +: 4] > `VCARB_PORT_SKIP) && (table_in[i*4 +: 4] <= `VCARB_PORT_MAX))) &&
              (table_in[i*4 +: 4] != egress_in);  // [RULE7]
    end
  end

  // search forward with wrap, so bad slots cost no period
  always_comb begin
    logic [3:0] idx;
    idx   = 4'h0;
    pick  = ptr_q;
    found = 1'b0;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      idx = ptr_q + k[3:0];                         // wraps naturally at sixteen
      if (ok[idx]) begin
        pick  = idx;                                // [RULE8]
        found = 1'b1;
      end
    end
  end

  // one grant per period, then move past the granted slot
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_q     <= 4'h0;
      grant_out <= '0;
    end else if (step_in) begin
      grant_out.valid <= found;
      grant_out.port  <= table_in[pick*4 +: 4];
      grant_out.slot  <= pick;
      ptr_q           <= pick + 4'h1;              // [RULE12]
    end
  end

  // granted port must be legal and not the egress port
  property p_grant_legal;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(step_in) ##1 grant_out.valid |-> (grant_out.port != egress_in) && (grant_out.port <= 4'h5) &&
      (grant_out.port != 4'h1);
  endproperty
  a_grant_legal: assert property (p_grant_legal) else $error("grant to invalid port"); // [RULE8]

  // after granting slot n with valid table the pointer sits at n+1
  property p_ascend;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    step_in |=> ptr_q == grant_out.slot + 4'h1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("slot pointer not ascending"); // [RULE12]
endmodule : vcarb_slot_scan

/* File: logic/vcarb_top.sv */
// vc0 port arbitration table registers, coherency status and arbiter
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "vcarb_defines.svh"
module vcarb_top
  import vcarb_pkg::*;
#(
  parameter logic [3:0] LOAD_CYCLES   = `VCARB_LOAD_CYCLES,   // cycles to latch the table
  parameter logic [7:0] PERIOD_CYCLES = `VCARB_PERIOD_CYCLES, // cycles per arbitration period
  parameter logic [3:0] EGRESS_ID     = 4'h0                  // own port id
) (
  input  wire logic        ref_clk_in,        // core clock, 100 mhz
  input  wire logic        rstn_in,           // async reset, active low
  input  wire logic [11:0] addr_in,           // register byte address
  input  wire logic [31:0] wdata_in,          // write data
  input  wire logic        wr_in,             // write strobe
  input  wire logic        rd_in,             // read strobe
  input  wire logic        upstream_in,       // port strap: 1 upstream, 0 downstream
  input  wire logic        table_scheme_in,   // selected scheme uses the table
  input  wire logic        fc_init_busy_in,   // flow control init in progress (async)
  output logic [31:0]      rdata_out,         // read data, cycle after rd_in
  output logic             grant_valid_out,   // grant names a real port
  output logic [3:0]       grant_port_out,    // granted ingress port
  output logic             coherency_out      // raw coherency flag
);
  logic [31:0]       tbl0_q;                  // slots 0..7
  logic [31:0]       tbl1_q;                  // slots 8..15
  logic [63:0]       live_q;                  // table the arbiter actually uses
  logic              coh_q;                   // coherency flag
  vcarb_load_state_t ld_state_q;              // load sequencer
  logic [3:0]        ld_cnt_q;                // load progress
  logic [7:0]        per_cnt_q;               // period divider
  logic              step_q;                  // one-cycle period pulse
  logic              fc_s1_q;                 // sync stage one
  logic              fc_s2_q;                 // sync stage two
  logic              up_s1_q;                 // strap sync stage one
  logic              up_q;                    // strap sync stage two
  vcarb_grant_t      grant;                   // from the scanner
  logic              tbl_wr;                  // any table word written
  logic              load_wr;                 // load request written with one
  logic              ld_done;                 // last latch cycle

  assign tbl_wr  = wr_in && ((addr_in == `VCARB_OFF_TBL0) || (addr_in == `VCARB_OFF_TBL1));
  assign load_wr = wr_in && (addr_in == `VCARB_OFF_CTRL) && wdata_in[`VCARB_BIT_LOAD_REQ] && up_q; // [RULE11]
  assign ld_done = (ld_state_q == VCARB_LOAD) && (ld_cnt_q == LOAD_CYCLES - 4'h1);

  // strap is a pin, so two stages before use; scheme select is same-clock logic and used as is
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_s1_q <= 1'b0;
      up_q    <= 1'b0;
    end else begin
      up_s1_q <= upstream_in;
      up_q    <= up_s1_q;
    end
  end

  // flow control busy arrives from another domain
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fc_s1_q <= 1'b0;
      fc_s2_q <= 1'b0;
    end else begin
      fc_s1_q <= fc_init_busy_in;
      fc_s2_q <= fc_s1_q;
    end
  end

  // table words, defaults cycle 1..7 across both words
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tbl0_q <= `VCARB_RST_TBL0;                // [RULE10]
      tbl1_q <= `VCARB_RST_TBL1;                // [RULE10]
    end else if (wr_in) begin
      if (addr_in == `VCARB_OFF_TBL0) begin
        tbl0_q <= wdata_in;                     // [RULE6]
      end
      if (addr_in == `VCARB_OFF_TBL1) begin
        tbl1_q <= wdata_in;                     // [RULE6]
      end
    end
  end

  // load sequencer copies the table after a fixed latch time
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ld_state_q <= VCARB_IDLE;
      ld_cnt_q   <= 4'h0;
      live_q     <= {`VCARB_RST_TBL1, `VCARB_RST_TBL0};
    end else begin
      case (ld_state_q)
        VCARB_IDLE: begin
          ld_cnt_q <= 4'h0;
          if (load_wr) begin
            ld_state_q <= VCARB_LOAD;           // [RULE11]
          end
        end
        VCARB_LOAD: begin
          ld_cnt_q <= ld_cnt_q + 4'h1;
          if (ld_done) begin
            live_q     <= {tbl1_q, tbl0_q};     // [RULE11]
            ld_state_q <= VCARB_IDLE;
          end
        end
        default: begin
          ld_state_q <= VCARB_IDLE;
        end
      endcase
    end
  end

  // coherency: a table write wins over load completion in the same cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      coh_q <= 1'b0;
    end else if (tbl_wr) begin
      coh_q <= 1'b1;                            // [RULE1]
    end else if (ld_done) begin
      coh_q <= 1'b0;                            // [RULE2]
    end
  end

  // period divider gives the scanner one step per period
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      per_cnt_q <= 8'h00;
      step_q    <= 1'b0;
    end else begin
      step_q <= (per_cnt_q == PERIOD_CYCLES - 8'h01);
      if (per_cnt_q == PERIOD_CYCLES - 8'h01) begin
        per_cnt_q <= 8'h00;
      end else begin
        per_cnt_q <= per_cnt_q + 8'h01;
      end
    end
  end

  vcarb_slot_scan #(
    .SLOTS(16)
  ) u_scan (
    .ref_clk_in(ref_clk_in),
    .rstn_in   (rstn_in),
    .step_in   (step_q),
    .table_in  (live_q),
    .egress_in (EGRESS_ID),
    .grant_out (grant)
  );

  // read mux, answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= `VCARB_RST_STATUS;
    end else if (rd_in) begin
      case (addr_in)
        `VCARB_OFF_STATUS: begin
          rdata_out <= 32'h00000000;
          // meaningful only with a table scheme; downstream forced zero
          rdata_out[`VCARB_BIT_COHERENCY] <= coh_q && up_q && table_scheme_in; // [RULE3] [RULE4]
          rdata_out[`VCARB_BIT_FC_PEND]   <= fc_s2_q;                    // [RULE5]
        end
        `VCARB_OFF_TBL0: rdata_out <= tbl0_q;
        `VCARB_OFF_TBL1: rdata_out <= tbl1_q;
        `VCARB_OFF_CTRL: rdata_out <= 32'h00000000; // [RULE11]
        default:         rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  // outputs straight from flops
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      grant_valid_out <= 1'b0;
      grant_port_out  <= 4'h0;
      coherency_out   <= 1'b0;
    end else begin
      grant_valid_out <= grant.valid;
      grant_port_out  <= grant.port;
      coherency_out   <= coh_q;
    end
  end

  // table write raises the flag next cycle
  property p_coh_set;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    tbl_wr |=> coh_q;
  endproperty
  a_coh_set: assert property (p_coh_set) else $error("coherency not set on write"); // [RULE1]

  // flag holds while a load is still running and nothing else clears it
  property p_coh_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    coh_q && !ld_done |=> coh_q;
  endproperty
  a_coh_hold: assert property (p_coh_hold) else $error("coherency dropped early"); // [RULE2]

  // load ends within 16 cycles of a request made while idle
  property p_load_done;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    load_wr && ld_state_q == VCARB_IDLE |-> ##[1:16] ld_done;
  endproperty
  a_load_done: assert property (p_load_done) else $error("load never completed"); // [RULE11]

  // downstream status read shows coherency zero
  property p_down_zero;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_STATUS && !up_q |=> !rdata_out[0];
  endproperty
  a_down_zero: assert property (p_down_zero) else $error("downstream coherency nonzero"); // [RULE3]

  // fc pending bit follows the synchronised input
  property p_fc;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_STATUS |=> rdata_out[1] == $past(fc_s2_q);
  endproperty
  a_fc: assert property (p_fc) else $error("fc pending bit wrong"); // [RULE5]

  // control register reads zero
  property p_ctrl_zero;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_CTRL |=> rdata_out == 32'h00000000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control read nonzero"); // [RULE11]

  // downstream load request is ignored
  property p_load_up_only;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    wr_in && addr_in == `VCARB_OFF_CTRL && !up_q && ld_state_q == VCARB_IDLE |=> ld_state_q == VCARB_IDLE;
  endproperty
  a_load_up_only: assert property (p_load_up_only) else $error("downstream load acted"); // [RULE11]

  // table word 0 reads back what was written
  property p_tbl_rw;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    wr_in && addr_in == `VCARB_OFF_TBL0 ##1 rd_in && addr_in == `VCARB_OFF_TBL0 && !wr_in
      |=> rdata_out == $past(wdata_in, 2);
  endproperty
  a_tbl_rw: assert property (p_tbl_rw) else $error("table readback mismatch"); // [RULE6]

  // load completion clears the flag unless a write lands in the same cycle
  property p_coh_clear;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    ld_done && !tbl_wr |=> !coh_q;
  endproperty
  a_coh_clear: assert property (p_coh_clear) else $error("coherency not cleared by load"); // [RULE2]

  // completion copies both stored words into the live table
  property p_load_copy;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    ld_done |=> (live_q[31:0] == $past(tbl0_q)) && (live_q[63:32] == $past(tbl1_q));
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("live table not latched"); // [RULE11]

  // the live table changes only at load completion
  property p_live_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !ld_done |=> $stable(live_q);
  endproperty
  a_live_hold: assert property (p_live_hold) else $error("live table changed without load"); // [RULE11]

  // a second request while loading neither restarts nor ends the load
  property p_load_busy;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    load_wr && ld_state_q == VCARB_LOAD && !ld_done |=> ld_state_q == VCARB_LOAD;
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("load disturbed by request"); // [RULE11]

  // scheme without table reads coherency as zero
  property p_status_gate;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_STATUS && !table_scheme_in |=> !rdata_out[0];
  endproperty
  a_status_gate: assert property (p_status_gate) else $error("coherency shown without table"); // [RULE4]

  // upstream with table scheme shows a pending flag
  property p_status_hi;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_STATUS && coh_q && up_q && table_scheme_in |=> rdata_out[0];
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("coherency flag hidden"); // [RULE1]

  // status bits above the two flags stay zero
  property p_status_rsvd;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `VCARB_OFF_STATUS |=> rdata_out[31:2] == 30'h0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status upper bits nonzero"); // [RULE5]

  // table words change only on a table write
  property p_tbl_keep;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !tbl_wr |=> $stable(tbl0_q) && $stable(tbl1_q);
  endproperty
  a_tbl_keep: assert property (p_tbl_keep) else $error("table changed without write"); // [RULE6]

  // period pulse is one cycle wide, so one slot per period
  property p_step_once;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    step_q |=> !step_q;
  endproperty
  a_step_once: assert property (p_step_once) else $error("period pulse too long"); // [RULE12]

  // the grant moves only on a period pulse
  property p_grant_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !step_q |=> $stable(grant);
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant moved between periods"); // [RULE12]
endmodule : vcarb_top

/* File: sim/vcarb_ingress_model.sv */
// ingress port model: flow control init timing and grant legality
`timescale 1ns/1ns
module vcarb_ingress_model #(
  parameter int FC_CYCLES = 40                 // cycles of init after reset
) (
  input  wire logic       ref_clk_in,          // core clock
  input  wire logic       rstn_in,             // async reset, active low
  input  wire logic       grant_valid_in,      // grant names a port
  input  wire logic [3:0] grant_port_in,       // granted ingress port
  output logic            fc_init_busy_out,    // init still running
  output logic            bad_grant_out        // sticky: grant to a non-port
);
  int fc_cnt_q;                                // init cycles left
  // init restarts on every reset, then stays done
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) fc_cnt_q <= FC_CYCLES;
    else if (fc_cnt_q > 0) fc_cnt_q <= fc_cnt_q - 1;
  end
  assign fc_init_busy_out = (fc_cnt_q != 0);
  // only ports 2..5 compete; port 0 is the egress side
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) bad_grant_out <= 1'b0;
    else if (grant_valid_in && (grant_port_in < 4'h2 || grant_port_in > 4'h5)) bad_grant_out <= 1'b1;
  end
endmodule : vcarb_ingress_model

/* File: sim/tb.sv */
// self-checking bench for the vc0 arbitration table
`timescale 1ns/1ns
`include "vcarb_defines.svh"
module tb;
  import vcarb_pkg::*;
  localparam int PER = 4;                      // arbitration period in cycles
  logic        ref_clk_in, rstn_in, wr_in, rd_in, upstream_in, table_scheme_in;
  logic [11:0] addr_in;                        // register address
  logic [31:0] wdata_in, rdata_out, d, seed;   // bus data and random state
  logic        grant_valid_out, coherency_out, fc_busy, bad_grant;
  logic [3:0]  grant_port_out, last;           // grant and last seen grant
  logic [31:0] tbl_m [2];                      // model of the two table words
  int          fail_count, n_tests, cyc, gap, nchg, idx;
  int          q [$];                          // expected valid port order
  vcarb_top i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .upstream_in(upstream_in), .table_scheme_in(table_scheme_in),
    .fc_init_busy_in(fc_busy), .rdata_out(rdata_out), .grant_valid_out(grant_valid_out),
    .grant_port_out(grant_port_out), .coherency_out(coherency_out));
  vcarb_ingress_model i_ports (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .grant_valid_in(grant_valid_out),
    .grant_port_in(grant_port_out), .fc_init_busy_out(fc_busy), .bad_grant_out(bad_grant));
  // clock and hang guard
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // one-cycle write, strobe dropped after the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
    if (a == `VCARB_OFF_TBL0 || a == `VCARB_OFF_TBL1) tbl_m[a[2]] = v;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] v, output logic [31:0] r);
    wr(a, v);
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 r = rdata_out;
  endtask : wr_rd
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // status model: coherency only shows on an upstream port using the table
  function automatic logic [31:0] st(input logic coh, input logic fc);
    return {30'h0, fc, coh & upstream_in & table_scheme_in};
  endfunction : st
  task automatic do_reset();
    rstn_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    for (int i = 0; i < 16; i++) tbl_m[i/8][(i%8)*4 +: 4] = 4'(i % 7 + 1);
  endtask : do_reset
  task automatic check_reset();
    rd(`VCARB_OFF_TBL0, d); chk(d, tbl_m[0]);
    rd(`VCARB_OFF_TBL1, d); chk(d, tbl_m[1]);
    rd(`VCARB_OFF_STATUS, d); chk(d, st(1'b0, 1'b1));
  endtask : check_reset
  initial begin
    seed = 32'h723f;
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    upstream_in = 1'b1;
    table_scheme_in = 1'b1;
    do_reset();
    check_reset();
    rd(12'h3fc, d); chk(d, 32'h0);
    $display("test reset values done");
    // random legal slots, read back; any table write marks it incoherent
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) d[i*4 +: 4] = 4'(xs() % 4 + 2);
      wr_rd(k[0] ? `VCARB_OFF_TBL1 : `VCARB_OFF_TBL0, d, d); chk(d, tbl_m[k%2]);
      rd(`VCARB_OFF_STATUS, d); chk(d[0], 1'b1);
    end
    $display("test table write done");
    // downstream or table unused: bit reads zero; downstream load ignored
    for (int j = 0; j < 3; j++) begin
      @(posedge ref_clk_in);
      upstream_in <= j[0];
      table_scheme_in <= j[1];
      repeat (2) @(posedge ref_clk_in);
      if (j == 0) wr(`VCARB_OFF_CTRL, 32'h0001_0000);
      repeat (12) @(posedge ref_clk_in);
      rd(`VCARB_OFF_STATUS, d); chk(d[0], st(1'b1, 1'b0) & 32'h1);
      chk(coherency_out, 1'b1);
    end
    @(posedge ref_clk_in);
    upstream_in <= 1'b1;
    table_scheme_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    $display("test status gating done");
    // write zero does nothing, control reads zero, one starts the load
    wr(`VCARB_OFF_CTRL, 32'h0);
    repeat (12) @(posedge ref_clk_in);
    rd(`VCARB_OFF_STATUS, d); chk(d[0], 1'b1);
    rd(`VCARB_OFF_CTRL, d); chk(d, 32'h0);
    wr(`VCARB_OFF_CTRL, 32'h0001_0000);
    rd(`VCARB_OFF_STATUS, d); chk(d[0], 1'b1);
    repeat (10) @(posedge ref_clk_in);
    rd(`VCARB_OFF_STATUS, d); chk(d, st(1'b0, 1'b0));
    $display("test load done");
    // ports 2..5 spread among port-1 slots, which are skipped; no reserved or egress codes
    wr(`VCARB_OFF_TBL0, 32'h1154_1312);
    wr(`VCARB_OFF_TBL1, 32'h1111_1111);
    wr(`VCARB_OFF_CTRL, 32'h0001_0000);
    repeat (14) @(posedge ref_clk_in);
    q = {};
    for (int i = 0; i < 16; i++) begin
      d[3:0] = tbl_m[i/8][(i%8)*4 +: 4];
      if (d[3:0] >= 4'h2 && d[3:0] <= 4'h5) q.push_back(d[3:0]);
    end
    {last, gap, nchg, idx} = '0;
    repeat (PER * 30) begin
      @(posedge ref_clk_in);
      #1 gap++;
      if (grant_port_out !== last) begin
        nchg++;
        if (nchg > 2) chk(gap, PER);
        if (nchg > 2) chk(grant_port_out, q[idx]);
        chk(grant_valid_out, 1'b1);
        for (int j = 0; j < q.size(); j++) if (q[j] == grant_port_out) idx = (j + 1) % q.size();
        last = grant_port_out;
        gap = 0;
      end
    end
    chk(nchg >= 20, 1'b1);
    chk(bad_grant, 1'b0);
    $display("test arbitration order done");
    // second reset mid-run restores the table and restarts init
    @(posedge ref_clk_in);
    do_reset();
    check_reset();
    $display("test second reset done");
    finish_test();
  end
endmodule : tb
